// file: test_video_dram_alpha_mode_sequencer.sv
// self-checking bench for the text-mode video dram sequencer
module test_video_dram_alpha_mode_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic graphics_mode = 1'b0;
   logic [1:0] video_clock_sel = 2'h0;
   logic memory_clock = 1'b0;
   logic video_clock_a = 1'b0;
   logic video_clock_b = 1'b0;
   logic video_clock_c = 1'b0;
   logic fetch_req = 1'b0;
   logic [8:0] fetch_row = 9'h000;
   logic [8:0] fetch_col = 9'h000;
   logic refresh_req = 1'b0;
   logic host_cmd_n = 1'b1;
   logic host_write = 1'b0;
   logic [8:0] host_row = 9'h000;
   logic [8:0] host_col = 9'h000;
   logic [15:0] host_wdata = 16'h0000;
   logic [1:0] host_bank_en = 2'h3;
   logic [3:0] host_plane_en = 4'hf;
   wire fetch_ack_r, refresh_ack_r, host_ready_r, host_ready_oe_r, memory_data_bus_oe;
   wire [15:0] fetch_rdata_r, host_rdata_r, memory_data_bus_in, memory_data_bus_out;
   wire [8:0] memory_row_col_address;
   wire row_strobe_low_bank_n, row_strobe_high_bank_n, column_strobe_low_bank_n, column_strobe_high_bank_n;
   wire output_enable_low_bank_n, output_enable_high_bank_n;
   wire write_enable_plane0_n, write_enable_plane1_n, write_enable_plane2_n, write_enable_plane3_n;
   int fail_count = 0;
   int comparisons = 0;
   vdas_sequencer i_vdas_sequencer (.*);
   vdas_dram_model i_vdas_dram_model (.*);
   // ==========================================================
   // clocks; slow pin clocks with offset phases, but memory_clock and video_clock_a land in one clk cycle, so a pick between them cannot show
   initial
   begin
      forever #25 clk = ~clk;
   end
   initial
   begin
      fork
         begin #207; forever #200 memory_clock = ~memory_clock; end
         begin #213; forever #200 video_clock_a = ~video_clock_a; end
         begin #288; forever #200 video_clock_b = ~video_clock_b; end
         begin #342; forever #200 video_clock_c = ~video_clock_c; end
      join
   end
   // ==========================================================
   // helpers
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD at %0t ns seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic set_mode(input logic [1:0] m);
      @(posedge clk);
      graphics_mode <= (m == 2'h3);
      video_clock_sel <= m;
      repeat (20) @(posedge clk);
   endtask
   task automatic host_op(input logic wr, input logic [8:0] row, input logic [8:0] col, input logic [15:0] wd,
      input logic [1:0] be);
      int n;
      @(posedge clk);
      host_write <= wr;
      host_row <= row;
      host_col <= col;
      host_wdata <= wd;
      host_bank_en <= be;
      host_cmd_n <= 1'b0;
      repeat (5) @(posedge clk);
      check({host_ready_oe_r, host_ready_r}, 2'h2);
      n = 5;
      while (!(host_ready_oe_r === 1'b1 && host_ready_r === 1'b1) && n < 100)
      begin
         @(posedge clk);
         n++;
      end
      check(n <= 41, 1'b1);
      host_cmd_n <= 1'b1;
      repeat (4) @(posedge clk);
      check(host_ready_oe_r, 1'b0);
      // a timed-out wait leaves the memory cycle running, so let it drain
      repeat (120) @(posedge clk);
   endtask
   task automatic fetch_op(input logic [8:0] row, input logic [8:0] col);
      int n;
      @(posedge clk);
      fetch_req <= 1'b1;
      fetch_row <= row;
      fetch_col <= col;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while (fetch_ack_r !== 1'b1 && n < 300);
      fetch_req <= 1'b0;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_mode(input logic [1:0] m);
      logic [15:0] d;
      logic [8:0] r;
      logic [8:0] c;
      d = 16'h3c5a + {14'h0, m};
      r = 9'h011 + {7'h0, m};
      c = 9'h120 + {7'h0, m};
      set_mode(m);
      host_op(1'b1, r, c, d, 2'h3);
      host_op(1'b0, r, c, 16'h0000, 2'h3);
      check(host_rdata_r, d);
      fetch_op(r, c);
      check(fetch_rdata_r, d);
   endtask
   task automatic t_banks;
      host_op(1'b1, 9'h014, 9'h123, 16'hffff, 2'h1);
      host_op(1'b1, 9'h014, 9'h123, 16'h0000, 2'h2);
      host_op(1'b0, 9'h014, 9'h123, 16'h0000, 2'h3);
      check(host_rdata_r, 16'h00ff);
      fetch_op(9'h014, 9'h123);
      check(fetch_rdata_r, 16'h00ff);
   endtask
   task automatic t_contention;
      int n;
      set_mode(2'h1);
      fork
         begin
            @(posedge clk);
            refresh_req <= 1'b1;
            n = 0;
            do
            begin
               @(posedge clk);
               n++;
            end while (refresh_ack_r !== 1'b1 && n < 200);
            refresh_req <= 1'b0;
            @(posedge clk);
            check(refresh_ack_r, 1'b0);
         end
         begin
            repeat (12) @(posedge clk);
            host_op(1'b0, 9'h011, 9'h120, 16'h0000, 2'h3);
         end
      join
      check(host_rdata_r, 16'h3c5a);
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial
   begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      check({row_strobe_low_bank_n, column_strobe_low_bank_n, host_ready_oe_r, memory_data_bus_oe}, 4'hc);
      for (int m = 0; m < 4; m++)
         t_mode(2'(m));
      t_banks;
      t_contention;
      test_done;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      test_done;
   end
endmodule

// file: vdas_clk_sel.v
// picks the timing clock and turns its edges into one-cycle ticks
`include "vdas_defines.vh"

module vdas_clk_sel (
   input wire clk,
   input wire nrst,
   input wire graphics_mode,
   input wire [1:0] video_clock_sel,
   input wire memory_clock,
   input wire video_clock_a,
   input wire video_clock_b,
   input wire video_clock_c,
   output reg rise_tick_r,
   output reg fall_tick_r
);

   // ==========================================================
   // three-stage synchronisers, one per source
   reg [3:0] s1_r;
   reg [3:0] s2_r;
   reg [3:0] s3_r;
   reg [3:0] lvl_r;
   reg [3:0] lvl_nxt;
   reg sel_lvl;
   reg sel_prev_r;
   integer i;

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s1_r <= 4'h0;
         s2_r <= 4'h0;
         s3_r <= 4'h0;
      end
      else
      begin
         s1_r <= {video_clock_c, video_clock_b, video_clock_a, memory_clock};
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // a level moves only once stages two and three agree
   always @*
   begin
      lvl_nxt = lvl_r;
      for (i = 0; i < 4; i = i + 1)
      begin
         if (s2_r[i] == s3_r[i])
            lvl_nxt[i] = s3_r[i];
      end
   end

   // ==========================================================
   // source choice: memory clock in graphics, one video clock in text
   always @*
   begin
      if (graphics_mode)
         sel_lvl = lvl_nxt[0];
      else
      begin
         case (video_clock_sel)
            `VDAS_SEL_A: sel_lvl = lvl_nxt[1];
            `VDAS_SEL_B: sel_lvl = lvl_nxt[2];
            `VDAS_SEL_C: sel_lvl = lvl_nxt[3];
            default: sel_lvl = lvl_nxt[1];
         endcase
      end
   end

   // switching source mid-access may give one short period
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         lvl_r <= 4'h0;
         sel_prev_r <= 1'b0;
         rise_tick_r <= 1'b0;
         fall_tick_r <= 1'b0;
      end
      else
      begin
         lvl_r <= lvl_nxt;
         sel_prev_r <= sel_lvl;
         rise_tick_r <= sel_lvl & ~sel_prev_r;
         fall_tick_r <= ~sel_lvl & sel_prev_r;
      end
   end

endmodule

// file: vdas_defines.vh
// shared constants of the text-mode video dram sequencer
`ifndef VDAS_DEFINES_VH
`define VDAS_DEFINES_VH

// ==========================================================
// clock and time
`define VDAS_CLK_MHZ 20
`define VDAS_READY_MAX_NS 2000
`define VDAS_READY_MAX_CYC ((`VDAS_READY_MAX_NS * `VDAS_CLK_MHZ) / 1000)
`define VDAS_CMD_SYNC_CYC 5

// ==========================================================
// strobe counts in periods of the selected clock
`define VDAS_RFR_ACT 3'h4
`define VDAS_RFR_PRE 3'h3
`define VDAS_CAS_ACT 3'h3
`define VDAS_CAS_PRE 3'h4
`define VDAS_WE_DELAY 3'h1
`define VDAS_WDATA_HOLD 3'h2
`define VDAS_CNT_W 3

// ==========================================================
// widths
`define VDAS_ADDR_W 9
`define VDAS_DATA_W 16
`define VDAS_PLANES 4

// ==========================================================
// clock source select codes
`define VDAS_SEL_A 2'h0
`define VDAS_SEL_B 2'h1
`define VDAS_SEL_C 2'h2

// ==========================================================
// sequencer states
`define VDAS_S_IDLE 3'h0
`define VDAS_S_ROW 3'h1
`define VDAS_S_RAS 3'h2
`define VDAS_S_COLA 3'h3
`define VDAS_S_CAS 3'h4
`define VDAS_S_PRE 3'h5
`define VDAS_S_END 3'h6
`define VDAS_S_RFR 3'h7

// ==========================================================
// access owners
`define VDAS_OWN_FETCH 2'h0
`define VDAS_OWN_HOST 2'h1
`define VDAS_OWN_RFR 2'h2

`endif

// file: vdas_dram_model.sv
// behavioural video dram array, two byte banks
module vdas_dram_model (
   input logic clk,
   input logic [8:0] memory_row_col_address,
   input logic row_strobe_low_bank_n,
   input logic row_strobe_high_bank_n,
   input logic column_strobe_low_bank_n,
   input logic column_strobe_high_bank_n,
   input logic output_enable_low_bank_n,
   input logic output_enable_high_bank_n,
   input logic write_enable_plane0_n,
   input logic write_enable_plane1_n,
   input logic write_enable_plane2_n,
   input logic write_enable_plane3_n,
   input logic [15:0] memory_data_bus_out,
   output logic [15:0] memory_data_bus_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem_lo [int];
   logic [7:0] mem_hi [int];
   logic [8:0] row_lo = 9'h000;
   logic [8:0] row_hi = 9'h000;
   int key_lo = 0;
   int key_hi = 0;
   // planes are not modelled separately: any write enable stores the word
   wire we_any_n = write_enable_plane0_n & write_enable_plane1_n & write_enable_plane2_n & write_enable_plane3_n;
   initial memory_data_bus_in = 16'h0000;
   always @(negedge row_strobe_low_bank_n) row_lo = memory_row_col_address;
   always @(negedge row_strobe_high_bank_n) row_hi = memory_row_col_address;
   always @(negedge column_strobe_low_bank_n) key_lo = {row_lo, memory_row_col_address};
   always @(negedge column_strobe_high_bank_n) key_hi = {row_hi, memory_row_col_address};
   // ==========================================================
   // data; an undriven bus toggles so a stale value is never read as good
   always @(posedge clk)
   begin
      if (!column_strobe_low_bank_n && !we_any_n)
         mem_lo[key_lo] = memory_data_bus_out[7:0];
      if (!column_strobe_high_bank_n && !we_any_n)
         mem_hi[key_hi] = memory_data_bus_out[15:8];
      if (!column_strobe_low_bank_n && !output_enable_low_bank_n)
         memory_data_bus_in[7:0] <= mem_lo.exists(key_lo) ? mem_lo[key_lo] : 8'h00;
      else
         memory_data_bus_in[7:0] <= ~memory_data_bus_in[7:0];
      if (!column_strobe_high_bank_n && !output_enable_high_bank_n)
         memory_data_bus_in[15:8] <= mem_hi.exists(key_hi) ? mem_hi[key_hi] : 8'h00;
      else
         memory_data_bus_in[15:8] <= ~memory_data_bus_in[15:8];
   end
endmodule

// file: vdas_seq_properties.sv
// pin-level timing checks for the text-mode video dram sequencer
module vdas_seq_checker (
   input logic clk,
   input logic nrst,
   input logic graphics_mode,
   input logic [1:0] video_clock_sel,
   input logic memory_clock,
   input logic video_clock_a,
   input logic video_clock_b,
   input logic video_clock_c,
   input logic host_cmd_n,
   input logic refresh_ack_r,
   input logic host_ready_r,
   input logic host_ready_oe_r,
   input logic row_strobe_low_bank_n,
   input logic column_strobe_low_bank_n,
   input logic output_enable_low_bank_n,
   input logic write_enable_plane0_n,
   input logic memory_data_bus_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   wire sel_clk = graphics_mode ? memory_clock : (video_clock_sel == 2'h1) ? video_clock_b :
      (video_clock_sel == 2'h2) ? video_clock_c : video_clock_a;
   logic sel_d_r;
   logic [3:0] rise_cnt_r;
   logic [3:0] fall_cnt_r;
   logic [7:0] cas_lo_r;
   logic [7:0] cas_hi_r;
   logic [7:0] wait_r;
   // counters saturate so a long idle gap never wraps into a false match
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sel_d_r <= 1'b0;
         rise_cnt_r <= 4'hf;
         fall_cnt_r <= 4'hf;
         cas_lo_r <= 8'h00;
         cas_hi_r <= 8'hff;
         wait_r <= 8'h00;
      end
      else
      begin
         sel_d_r <= sel_clk;
         rise_cnt_r <= (sel_clk && !sel_d_r) ? 4'h0 : (rise_cnt_r == 4'hf) ? rise_cnt_r : rise_cnt_r + 4'h1;
         fall_cnt_r <= (!sel_clk && sel_d_r) ? 4'h0 : (fall_cnt_r == 4'hf) ? fall_cnt_r : fall_cnt_r + 4'h1;
         cas_lo_r <= column_strobe_low_bank_n ? 8'h00 : (cas_lo_r == 8'hff) ? cas_lo_r : cas_lo_r + 8'h01;
         cas_hi_r <= !column_strobe_low_bank_n ? 8'h00 : (cas_hi_r == 8'hff) ? cas_hi_r : cas_hi_r + 8'h01;
         if (host_cmd_n || (host_ready_oe_r && host_ready_r))
            wait_r <= 8'h00;
         else if (wait_r != 8'hff)
            wait_r <= wait_r + 8'h01;
      end
   end
   // ==========================================================
   // properties
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!nrst);
   a_refresh_len: assert property ((!graphics_mode && $rose(refresh_ack_r)) |->
      row_strobe_low_bank_n && $past(row_strobe_low_bank_n, 20) && !$past(row_strobe_low_bank_n, 28)
      && !$past(row_strobe_low_bank_n, 50))
      else $error("refresh timing");
   a_cas_active: assert property ($rose(column_strobe_low_bank_n) |-> cas_lo_r == 8'd24)
      else $error("column strobe width");
   a_cas_precharge: assert property ($fell(column_strobe_low_bank_n) |-> cas_hi_r >= 8'd32)
      else $error("column precharge short");
   a_row_on_rise: assert property ((!graphics_mode && $changed(row_strobe_low_bank_n)) |->
      rise_cnt_r inside {[3:6]})
      else $error("row strobe edge");
   a_cas_on_fall: assert property ((!graphics_mode && $changed(column_strobe_low_bank_n)) |->
      fall_cnt_r inside {[3:6]})
      else $error("column strobe edge");
   a_oe_with_cas: assert property ($changed(output_enable_low_bank_n) |->
      $changed(column_strobe_low_bank_n))
      else $error("output enable apart");
   a_we_on_fall: assert property ((!graphics_mode && $changed(write_enable_plane0_n)) |->
      fall_cnt_r inside {[3:6]})
      else $error("write enable edge");
   a_data_setup: assert property ($fell(write_enable_plane0_n) |->
      memory_data_bus_oe && $past(memory_data_bus_oe, 12))
      else $error("data setup short");
   a_data_hold: assert property ($fell(memory_data_bus_oe) |->
      write_enable_plane0_n && $past(write_enable_plane0_n, 16))
      else $error("data hold short");
   a_ready_bound: assert property (!host_cmd_n |-> wait_r <= 8'd40)
      else $error("ready late");
   a_ready_release: assert property ($rose(host_cmd_n) |-> ##[1:3] !host_ready_oe_r)
      else $error("ready pin not released");
   a_ready_held: assert property ($fell(host_cmd_n) |-> ##[2:5] (host_ready_oe_r && !host_ready_r))
      else $error("ready not low");
endmodule

bind vdas_sequencer vdas_seq_checker i_vdas_seq_checker (.*);

// file: vdas_sequencer.v
// text-mode video dram sequencer with refresh, fetch and host arbitration
//
// Summary of operation
// - memory cycles are timed in periods of the memory clock in graphics or the chosen video clock in text.
// - a refresh holds the row strobe low for 4 periods then high for 3 periods of precharge.
// - a column access holds the column strobe low for 3 periods and high for 4 periods of precharge.
// - the row address is launched on a falling edge of the selected clock.
// - the address switches to the column address on a rising edge of the selected clock.
// - the row strobe is asserted and released on rising edges in text accesses.
// - the column strobe is asserted and released on falling edges in text accesses.
// - output enable moves on falling edges in reads and read data is captured at the column strobe.
// - write enable moves on falling edges in writes.
// - write data stands 1.5 periods before write enable and is held 2 periods after it.
// - host ready stays low for a variable time set by contention and clock phase.
// - host ready goes high no later than 2000 ns after the host command turns active, except when it is taken up in the cycle a previous host access ends.
// - after the host command ends the ready pin is released to high impedance within 180 ns.
// - lower and upper banks have separate strobes, upper column strobe on rising edges in graphics.
`include "vdas_defines.vh"

module vdas_sequencer #(
   parameter ADDR_W = `VDAS_ADDR_W,
   parameter DATA_W = `VDAS_DATA_W
) (
   input wire clk,
   input wire nrst,
   input wire graphics_mode,
   input wire [1:0] video_clock_sel,
   input wire memory_clock,
   input wire video_clock_a,
   input wire video_clock_b,
   input wire video_clock_c,
   input wire fetch_req,
   input wire [ADDR_W-1:0] fetch_row,
   input wire [ADDR_W-1:0] fetch_col,
   output reg fetch_ack_r,
   output reg [DATA_W-1:0] fetch_rdata_r,
   input wire refresh_req,
   output reg refresh_ack_r,
   input wire host_cmd_n,
   input wire host_write,
   input wire [ADDR_W-1:0] host_row,
   input wire [ADDR_W-1:0] host_col,
   input wire [DATA_W-1:0] host_wdata,
   input wire [1:0] host_bank_en,
   input wire [`VDAS_PLANES-1:0] host_plane_en,
   output reg [DATA_W-1:0] host_rdata_r,
   output reg host_ready_r,
   output reg host_ready_oe_r,
   output reg [ADDR_W-1:0] memory_row_col_address,
   output reg row_strobe_low_bank_n,
   output reg row_strobe_high_bank_n,
   output reg column_strobe_low_bank_n,
   output reg column_strobe_high_bank_n,
   output reg output_enable_low_bank_n,
   output reg output_enable_high_bank_n,
   output reg write_enable_plane0_n,
   output reg write_enable_plane1_n,
   output reg write_enable_plane2_n,
   output reg write_enable_plane3_n,
   input wire [DATA_W-1:0] memory_data_bus_in,
   output reg [DATA_W-1:0] memory_data_bus_out,
   output reg memory_data_bus_oe
);

   // ==========================================================
   // edge ticks of the selected clock
   wire rise;
   wire fall;

   vdas_clk_sel u_clk_sel (
      .clk(clk),
      .nrst(nrst),
      .graphics_mode(graphics_mode),
      .video_clock_sel(video_clock_sel),
      .memory_clock(memory_clock),
      .video_clock_a(video_clock_a),
      .video_clock_b(video_clock_b),
      .video_clock_c(video_clock_c),
      .rise_tick_r(rise),
      .fall_tick_r(fall)
   );

   // ==========================================================
   // host command synchroniser
   reg cmd_s1_r;
   reg cmd_s2_r;
   reg cmd_s3_r;
   reg cmd_act_r;
   wire cmd_act_nxt;

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cmd_s1_r <= 1'b0;
         cmd_s2_r <= 1'b0;
         cmd_s3_r <= 1'b0;
         cmd_act_r <= 1'b0;
      end
      else
      begin
         cmd_s1_r <= ~host_cmd_n;
         cmd_s2_r <= cmd_s1_r;
         cmd_s3_r <= cmd_s2_r;
         cmd_act_r <= cmd_act_nxt;
      end
   end

   assign cmd_act_nxt = (cmd_s2_r == cmd_s3_r) ? cmd_s3_r : cmd_act_r;

   // ==========================================================
   // shared helper
   function last_period;
      input [`VDAS_CNT_W-1:0] cnt;
      input [`VDAS_CNT_W-1:0] len;
      begin
         last_period = ((cnt + 3'h1) == len);
      end
   endfunction

   // ==========================================================
   // sequencer state
   reg [2:0] state_r;
   reg [1:0] owner_r;
   reg is_write_r;
   reg [1:0] bank_r;
   reg [`VDAS_PLANES-1:0] plane_r;
   reg [ADDR_W-1:0] col_r;
   reg [`VDAS_CNT_W-1:0] cnt_r;
   reg host_pend_r;
   reg host_busy_r;
   reg [6:0] wait_r;
   wire host_want;
   wire wait_over;

   assign host_want = host_pend_r & ~host_busy_r;
   // wait count starts a few edges after the pin, so take those off the bound
   assign wait_over = (wait_r == (`VDAS_READY_MAX_CYC - `VDAS_CMD_SYNC_CYC));

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_r <= `VDAS_S_IDLE;
         owner_r <= `VDAS_OWN_FETCH;
         is_write_r <= 1'b0;
         bank_r <= 2'h0;
         plane_r <= {`VDAS_PLANES{1'b0}};
         col_r <= {ADDR_W{1'b0}};
         cnt_r <= {`VDAS_CNT_W{1'b0}};
         host_pend_r <= 1'b0;
         host_busy_r <= 1'b0;
         wait_r <= 7'h0;
         fetch_ack_r <= 1'b0;
         fetch_rdata_r <= {DATA_W{1'b0}};
         refresh_ack_r <= 1'b0;
         host_rdata_r <= {DATA_W{1'b0}};
         host_ready_r <= 1'b1;
         host_ready_oe_r <= 1'b0;
         memory_row_col_address <= {ADDR_W{1'b0}};
         row_strobe_low_bank_n <= 1'b1;
         row_strobe_high_bank_n <= 1'b1;
         column_strobe_low_bank_n <= 1'b1;
         column_strobe_high_bank_n <= 1'b1;
         output_enable_low_bank_n <= 1'b1;
         output_enable_high_bank_n <= 1'b1;
         write_enable_plane0_n <= 1'b1;
         write_enable_plane1_n <= 1'b1;
         write_enable_plane2_n <= 1'b1;
         write_enable_plane3_n <= 1'b1;
         memory_data_bus_out <= {DATA_W{1'b0}};
         memory_data_bus_oe <= 1'b0;
      end
      else
      begin
         fetch_ack_r <= 1'b0;
         refresh_ack_r <= 1'b0;
         // release looks at stage two alone; waiting for agreement is too slow
         if (cmd_act_nxt && !cmd_act_r)
         begin
            host_pend_r <= 1'b1;
            host_ready_r <= 1'b0;
            host_ready_oe_r <= 1'b1;
            wait_r <= 7'h0;
         end
         else if (!cmd_s2_r && cmd_act_r)
         begin
            host_ready_oe_r <= 1'b0;
            host_ready_r <= 1'b1;
         end
         else if (host_pend_r && !host_ready_r)
         begin
            wait_r <= wait_r + 7'h1;
            // stuck clock must not hang the host bus
            if (wait_over)
               host_ready_r <= 1'b1;
         end
         case (state_r)
            `VDAS_S_IDLE:
            begin
               cnt_r <= {`VDAS_CNT_W{1'b0}};
               // host first, then refresh, then display fetch
               if (fall && (host_want || refresh_req || fetch_req))
               begin
                  state_r <= `VDAS_S_ROW;
                  if (host_want)
                  begin
                     owner_r <= `VDAS_OWN_HOST;
                     host_busy_r <= 1'b1;
                     is_write_r <= host_write;
                     bank_r <= host_bank_en;
                     plane_r <= host_plane_en;
                     col_r <= host_col;
                     memory_row_col_address <= host_row;
                  end
                  else if (refresh_req)
                  begin
                     owner_r <= `VDAS_OWN_RFR;
                     is_write_r <= 1'b0;
                     bank_r <= 2'h3;
                  end
                  else
                  begin
                     owner_r <= `VDAS_OWN_FETCH;
                     is_write_r <= 1'b0;
                     bank_r <= 2'h3;
                     col_r <= fetch_col;
                     memory_row_col_address <= fetch_row;
                  end
               end
            end
            `VDAS_S_ROW:
               if (rise)
               begin
                  row_strobe_low_bank_n <= ~bank_r[0];
                  row_strobe_high_bank_n <= ~bank_r[1];
                  state_r <= (owner_r == `VDAS_OWN_RFR) ? `VDAS_S_RFR : `VDAS_S_RAS;
               end
            `VDAS_S_RAS:
               if (rise)
               begin
                  memory_row_col_address <= col_r;
                  if (is_write_r)
                  begin
                     memory_data_bus_out <= host_wdata;
                     memory_data_bus_oe <= 1'b1;
                  end
                  state_r <= `VDAS_S_COLA;
               end
            `VDAS_S_COLA:
               if (fall)
               begin
                  column_strobe_low_bank_n <= ~bank_r[0];
                  if (!graphics_mode)
                     column_strobe_high_bank_n <= ~bank_r[1];
                  if (!is_write_r)
                  begin
                     output_enable_low_bank_n <= ~bank_r[0];
                     output_enable_high_bank_n <= ~bank_r[1];
                  end
                  state_r <= `VDAS_S_CAS;
               end
            `VDAS_S_CAS:
            begin
               // upper bank follows the rising edge in graphics modes
               if (rise && graphics_mode)
                  column_strobe_high_bank_n <= ~bank_r[1] | (cnt_r == `VDAS_CAS_ACT);
               if (fall)
               begin
                  cnt_r <= cnt_r + 3'h1;
                  if (is_write_r && last_period(cnt_r, `VDAS_WE_DELAY))
                  begin
                     write_enable_plane0_n <= ~plane_r[0];
                     write_enable_plane1_n <= ~plane_r[1];
                     write_enable_plane2_n <= ~plane_r[2];
                     write_enable_plane3_n <= ~plane_r[3];
                  end
                  if (last_period(cnt_r, `VDAS_CAS_ACT))
                  begin
                     cnt_r <= {`VDAS_CNT_W{1'b0}};
                     column_strobe_low_bank_n <= 1'b1;
                     if (!graphics_mode)
                        column_strobe_high_bank_n <= 1'b1;
                     output_enable_low_bank_n <= 1'b1;
                     output_enable_high_bank_n <= 1'b1;
                     write_enable_plane0_n <= 1'b1;
                     write_enable_plane1_n <= 1'b1;
                     write_enable_plane2_n <= 1'b1;
                     write_enable_plane3_n <= 1'b1;
                     if (!is_write_r && owner_r == `VDAS_OWN_HOST)
                        host_rdata_r <= memory_data_bus_in;
                     if (!is_write_r && owner_r == `VDAS_OWN_FETCH)
                        fetch_rdata_r <= memory_data_bus_in;
                     state_r <= `VDAS_S_PRE;
                  end
               end
            end
            `VDAS_S_PRE:
            begin
               if (rise && graphics_mode)
                  column_strobe_high_bank_n <= 1'b1;
               if (fall)
               begin
                  cnt_r <= cnt_r + 3'h1;
                  if (last_period(cnt_r, `VDAS_WDATA_HOLD))
                     memory_data_bus_oe <= 1'b0;
                  if (last_period(cnt_r, `VDAS_CAS_PRE))
                  begin
                     cnt_r <= {`VDAS_CNT_W{1'b0}};
                     state_r <= `VDAS_S_END;
                  end
               end
            end
            `VDAS_S_END:
               if (rise)
               begin
                  row_strobe_low_bank_n <= 1'b1;
                  row_strobe_high_bank_n <= 1'b1;
                  state_r <= `VDAS_S_IDLE;
                  if (owner_r == `VDAS_OWN_HOST)
                  begin
                     host_busy_r <= 1'b0;
                     host_pend_r <= 1'b0;
                     // ready only if the command is still on the bus
                     if (cmd_act_r)
                        host_ready_r <= 1'b1;
                  end
                  else
                     fetch_ack_r <= 1'b1;
               end
            `VDAS_S_RFR:
               if (rise)
               begin
                  cnt_r <= cnt_r + 3'h1;
                  if (!row_strobe_low_bank_n && last_period(cnt_r, `VDAS_RFR_ACT))
                  begin
                     cnt_r <= {`VDAS_CNT_W{1'b0}};
                     row_strobe_low_bank_n <= 1'b1;
                     row_strobe_high_bank_n <= 1'b1;
                  end
                  else if (row_strobe_low_bank_n && last_period(cnt_r, `VDAS_RFR_PRE))
                  begin
                     refresh_ack_r <= 1'b1;
                     state_r <= `VDAS_S_IDLE;
                  end
               end
            default:
               state_r <= `VDAS_S_IDLE;
         endcase
      end
   end

endmodule
